// file: i2creg_defs.svh
/*
  Register offsets, field positions, reset values and field widths for the
  two-wire controller register front end.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef I2CREG_DEFS_SVH
`define I2CREG_DEFS_SVH

// Register byte offsets
`define I2CREG_OFS_OWN_ADDR   8'h00
`define I2CREG_OFS_INT_EN     8'h04
`define I2CREG_OFS_INT_STAT   8'h08
`define I2CREG_OFS_SCL_LOW    8'h0C
`define I2CREG_OFS_SCL_HIGH   8'h10
`define I2CREG_OFS_XFER_CNT   8'h14
`define I2CREG_OFS_RX_DATA    8'h18
`define I2CREG_OFS_TGT_ADDR   8'h1C
`define I2CREG_OFS_TX_DATA    8'h20
`define I2CREG_OFS_MODE       8'h24
`define I2CREG_OFS_INT_SRC    8'h28
`define I2CREG_OFS_EXT_MODE   8'h2C
`define I2CREG_OFS_PRESCALE   8'h30
`define I2CREG_OFS_PID_ONE    8'h34
`define I2CREG_OFS_PID_TWO    8'h38
`define I2CREG_OFS_PIN_FUNC   8'h48
`define I2CREG_OFS_PIN_DIR    8'h4C
`define I2CREG_OFS_PIN_IN     8'h50
`define I2CREG_OFS_PIN_OUT    8'h54
`define I2CREG_OFS_PIN_SET    8'h58
`define I2CREG_OFS_PIN_CLR    8'h5C

// Field positions and widths
`define I2CREG_OWN_ADDRESS_FIELD_W        10
`define I2CREG_NSRC           7
`define I2CREG_MODE_FREE_BIT  14
`define I2CREG_MODE_RUN_BIT   5
`define I2CREG_MODE_XA_BIT    8
`define I2CREG_STAT_RRDY_BIT  3
`define I2CREG_STAT_XRDY_BIT  4

// Reset values
`define I2CREG_STAT_RST       7'h10
`define I2CREG_PID_ONE_VAL    32'h0000_0A5A
`define I2CREG_PID_TWO_VAL    32'h0000_0001

`endif

// file: i2creg_pkg.sv
/*
  Types shared by the register front end and its source arbiter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package i2creg_pkg;

  // Interrupt source codes as reported in the source register
  typedef enum logic [2:0] {
    I2CREG_SRC_NONE = 3'h0,
    I2CREG_SRC_AL   = 3'h1,
    I2CREG_SRC_NACK = 3'h2,
    I2CREG_SRC_REGISTER_ACCESS_READY = 3'h3,
    I2CREG_SRC_RRDY = 3'h4,
    I2CREG_SRC_XRDY = 3'h5,
    I2CREG_SRC_SCD  = 3'h6,
    I2CREG_SRC_AAS  = 3'h7
  } i2creg_src_t;

  // Reporting state of the interrupt line
  typedef enum logic [1:0] {
    I2CREG_ST_IDLE = 2'b01,
    I2CREG_ST_REQ  = 2'b10
  } i2creg_irq_st_t;

endpackage

// file: i2creg_src_if.sv
/*
  Carrier between the register bank and the source arbiter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface i2creg_src_if;
  logic [6:0] pending;
  logic [2:0] code;
  logic       any;

  modport bank (output pending, input code, input any);
  modport arb  (input pending, output code, output any);
endinterface

// file: i2creg_src_arb.sv
/*
  Picks the lowest-numbered pending enabled source and encodes it.
  Assumes pending already holds flag AND enable per source.
*/
`timescale 1ns/1ns
module i2creg_src_arb
  import i2creg_pkg::*;
(
  // Carrier
  i2creg_src_if.arb src
);

  ////////////////////////////////////////////////////////////////////////
  // Priority encode, arbitration lost first
  always_comb begin
    src.code = 3'h0;
    src.any  = |src.pending;
    for (int i = 6; i >= 0; i--) begin
      if (src.pending[i]) begin
        src.code = 3'(i + 1);
      end
    end
  end

endmodule // i2creg_src_arb

// file: i2creg_top.sv
/*
  APB register front end of a two-wire serial bus controller: address map,
  own address with 7/10-bit match, per-source interrupt enables, read side
  effects of receive data and interrupt source registers, module run bit.
  Assumes an APB master on pclk and a protocol engine feeding event pulses
  and received bytes; the shifting and pin timing live outside this block.
*/
`timescale 1ns/1ns
`include "i2creg_defs.svh"
module i2creg_top
  import i2creg_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Protocol engine events, one-cycle pulses on pclk
  input  wire logic [6:0]  evt_set,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic [9:0]  bus_addr,
  // Engine control and status
  output logic             addr_match,
  output logic             engine_run,
  output logic             irq,
  // Bus pins, open drain
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_oe,
  output logic             sda_oe,
  output logic             scl_out,
  output logic             sda_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [`I2CREG_OWN_ADDRESS_FIELD_W-1:0] own_addr_q;
  logic [6:0]  int_en_q;
  logic [6:0]  flags_q;
  logic [31:0] scl_low_q;
  logic [31:0] scl_high_q;
  logic [15:0] xfer_cnt_q;
  logic [7:0]  rx_data_q;
  logic [9:0]  tgt_addr_q;
  logic [7:0]  tx_data_q;
  logic [15:0] mode_q;
  logic [31:0] ext_mode_q;
  logic [7:0]  prescale_q;
  logic [1:0]  pin_func_q;
  logic [1:0]  pin_dir_q;
  logic [1:0]  pin_out_q;
  logic [1:0]  pin_in_meta_q;
  logic [1:0]  pin_in_q;
  logic [2:0]  src_rep_q;
  i2creg_irq_st_t irq_st_q;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit;
  logic [31:0] rdata;
  logic        run;
  logic        rd_rx;
  logic        rd_src;
  logic        src_hold;
  logic [6:0]  w1c;
  logic [6:0]  rd_clr;

  i2creg_src_if src ();

  i2creg_src_arb u_arb (
    .src (src)
  );

  ////////////////////////////////////////////////////////////////////////
  // Access strobes; single-cycle access phase
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign run    = mode_q[`I2CREG_MODE_RUN_BIT];
  assign rd_rx  = rd_acc & (paddr == `I2CREG_OFS_RX_DATA);
  assign rd_src = rd_acc & (paddr == `I2CREG_OFS_INT_SRC);
  // Source register addressed, setup or access; its code must not move
  assign src_hold = psel & (paddr == `I2CREG_OFS_INT_SRC);

  // Arbiter sees pending enabled sources
  assign src.pending = flags_q & int_en_q;

  ////////////////////////////////////////////////////////////////////////
  // Read mux; an unmapped hole answers zero with pslverr
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    if (paddr == `I2CREG_OFS_OWN_ADDR) begin
      rdata = {22'h0, own_addr_q};
    end else if (paddr == `I2CREG_OFS_INT_EN) begin
      rdata = {25'h0, int_en_q};
    end else if (paddr == `I2CREG_OFS_INT_STAT) begin
      rdata = {25'h0, flags_q};
    end else if (paddr == `I2CREG_OFS_SCL_LOW) begin
      rdata = scl_low_q;
    end else if (paddr == `I2CREG_OFS_SCL_HIGH) begin
      rdata = scl_high_q;
    end else if (paddr == `I2CREG_OFS_XFER_CNT) begin
      rdata = {16'h0, xfer_cnt_q};
    end else if (paddr == `I2CREG_OFS_RX_DATA) begin
      rdata = {24'h0, rx_data_q};
    end else if (paddr == `I2CREG_OFS_TGT_ADDR) begin
      rdata = {22'h0, tgt_addr_q};
    end else if (paddr == `I2CREG_OFS_TX_DATA) begin
      rdata = {24'h0, tx_data_q};
    end else if (paddr == `I2CREG_OFS_MODE) begin
      rdata = {16'h0, mode_q};
    end else if (paddr == `I2CREG_OFS_INT_SRC) begin
      rdata = {29'h0, src_rep_q};
    end else if (paddr == `I2CREG_OFS_EXT_MODE) begin
      rdata = ext_mode_q;
    end else if (paddr == `I2CREG_OFS_PRESCALE) begin
      rdata = {24'h0, prescale_q};
    end else if (paddr == `I2CREG_OFS_PID_ONE) begin
      rdata = `I2CREG_PID_ONE_VAL;  // Arbitrary identification value
    end else if (paddr == `I2CREG_OFS_PID_TWO) begin
      rdata = `I2CREG_PID_TWO_VAL;  // Arbitrary identification value
    end else if (paddr == `I2CREG_OFS_PIN_FUNC) begin
      rdata = {30'h0, pin_func_q};
    end else if (paddr == `I2CREG_OFS_PIN_DIR) begin
      rdata = {30'h0, pin_dir_q};
    end else if (paddr == `I2CREG_OFS_PIN_IN) begin
      rdata = {30'h0, pin_in_q};
    end else if (paddr == `I2CREG_OFS_PIN_OUT) begin
      rdata = {30'h0, pin_out_q};
    end else if (paddr == `I2CREG_OFS_PIN_SET) begin
      rdata = 32'h0000_0000;  // Write-only
    end else if (paddr == `I2CREG_OFS_PIN_CLR) begin
      rdata = 32'h0000_0000;  // Write-only
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer registered; zero wait state, pready always high after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Plain configuration registers; reserved bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr_q <= 10'h000;
      int_en_q   <= 7'h00;
      scl_low_q  <= 32'h0000_0000;
      scl_high_q <= 32'h0000_0000;
      xfer_cnt_q <= 16'h0000;
      tgt_addr_q <= 10'h3FF;
      tx_data_q  <= 8'h00;
      mode_q     <= 16'h0000;
      ext_mode_q <= 32'h0000_0001;
      prescale_q <= 8'h00;
    end else if (wr_acc) begin
      if (paddr == `I2CREG_OFS_OWN_ADDR) begin
        own_addr_q <= pwdata[9:0];
      end else if (paddr == `I2CREG_OFS_INT_EN) begin
        int_en_q <= pwdata[6:0];
      end else if (paddr == `I2CREG_OFS_SCL_LOW) begin
        scl_low_q <= pwdata;
      end else if (paddr == `I2CREG_OFS_SCL_HIGH) begin
        scl_high_q <= pwdata;
      end else if (paddr == `I2CREG_OFS_XFER_CNT) begin
        xfer_cnt_q <= pwdata[15:0];
      end else if (paddr == `I2CREG_OFS_TGT_ADDR) begin
        tgt_addr_q <= pwdata[9:0];
      end else if (paddr == `I2CREG_OFS_TX_DATA) begin
        tx_data_q <= pwdata[7:0];
      end else if (paddr == `I2CREG_OFS_MODE) begin
        mode_q <= pwdata[15:0];  // Free-run bit kept for readback only
      end else if (paddr == `I2CREG_OFS_EXT_MODE) begin
        ext_mode_q <= pwdata;
      end else if (paddr == `I2CREG_OFS_PRESCALE) begin
        prescale_q <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin function registers with set and clear strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_func_q <= 2'h0;
      pin_dir_q  <= 2'h0;
      pin_out_q  <= 2'h0;
    end else if (wr_acc) begin
      if (paddr == `I2CREG_OFS_PIN_FUNC) begin
        pin_func_q <= pwdata[1:0];
      end else if (paddr == `I2CREG_OFS_PIN_DIR) begin
        pin_dir_q <= pwdata[1:0];
      end else if (paddr == `I2CREG_OFS_PIN_OUT) begin
        pin_out_q <= pwdata[1:0];
      end else if (paddr == `I2CREG_OFS_PIN_SET) begin
        pin_out_q <= pin_out_q | pwdata[1:0];
      end else if (paddr == `I2CREG_OFS_PIN_CLR) begin
        pin_out_q <= pin_out_q & ~pwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs cross in through two flops; bit 0 clock line, bit 1 data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_in_meta_q <= 2'h3;
      pin_in_q      <= 2'h3;
    end else begin
      pin_in_meta_q <= {sda_in, scl_in};
      pin_in_q      <= pin_in_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clear terms: write-one-to-clear and source-read clear
  assign w1c    = (wr_acc && paddr == `I2CREG_OFS_INT_STAT) ? pwdata[6:0] : 7'h00;
  assign rd_clr = (rd_src && src_rep_q != 3'h0) ? 7'(7'h01 << (src_rep_q - 3'h1)) : 7'h00;

  ////////////////////////////////////////////////////////////////////////
  // Status flags; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `I2CREG_STAT_RST;
    end else if (!run) begin
      flags_q <= `I2CREG_STAT_RST;
    end else begin
      for (int i = 0; i < `I2CREG_NSRC; i++) begin
        if (evt_set[i] || (i == `I2CREG_STAT_RRDY_BIT && rx_byte_valid)) begin
          flags_q[i] <= 1'b1;
        end else if (w1c[i] || rd_clr[i] || (i == `I2CREG_STAT_RRDY_BIT && rd_rx)) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive data holding register, loaded as each byte lands while the run bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q <= 8'h00;
    end else if (rx_byte_valid && run) begin
      rx_data_q <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source report and request line. A source read drops the request for
  // one cycle so the next pending source shows as a fresh rising edge.
  // The code is frozen while the source register is addressed, so the
  // flag cleared at the access edge is the one the read returned.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q  <= I2CREG_ST_IDLE;
      src_rep_q <= 3'h0;
      irq       <= 1'b0;
    end else begin
      case (irq_st_q)
        I2CREG_ST_IDLE: begin
          irq <= 1'b0;
          if (!src_hold) begin
            if (src.any) begin
              irq_st_q  <= I2CREG_ST_REQ;
              src_rep_q <= src.code;
              irq       <= 1'b1;
            end else begin
              src_rep_q <= 3'h0;
            end
          end
        end
        I2CREG_ST_REQ: begin
          if (rd_src || !src.any) begin
            irq_st_q <= I2CREG_ST_IDLE;
            irq      <= 1'b0;
          end else if (!src_hold) begin
            src_rep_q <= src.code;
          end
        end
        default: begin
          irq_st_q <= I2CREG_ST_IDLE;
          irq      <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address match and pin drive; pins released while the run bit is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_match <= 1'b0;
      engine_run <= 1'b0;
      scl_oe     <= 1'b0;
      sda_oe     <= 1'b0;
      scl_out    <= 1'b0;
      sda_out    <= 1'b0;
    end else begin
      engine_run <= run;
      if (mode_q[`I2CREG_MODE_XA_BIT]) begin
        addr_match <= run & (bus_addr == own_addr_q);
      end else begin
        addr_match <= run & (bus_addr[6:0] == own_addr_q[6:0]);
      end
      // Open drain: enable means pulling low
      scl_oe  <= ~run & pin_func_q[0] & pin_dir_q[0] & ~pin_out_q[0];
      sda_oe  <= ~run & pin_func_q[0] & pin_dir_q[1] & ~pin_out_q[1];
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

endmodule // i2creg_top

// file: i2creg_apb_host.sv
/*
  APB master model standing in for the host processor.
  Assumes a slave on pclk; waits for pready with no limit of its own.
*/
`timescale 1ns/1ns
module i2creg_apb_host (
  // Clock
  input  wire logic        pclk,
  // Slave answer
  input  wire logic        pready,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One transfer; an idle edge first so back-to-back calls never collide
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Stale data inverted so a late sample cannot pass by luck
    pwdata  <= ~d;
  endtask
endmodule // i2creg_apb_host

// file: i2creg_top_checker.sv
/*
  Concurrent checks on the register front end, from its top ports only.
  Assumes zero-wait APB answers and one clock domain.
*/
`timescale 1ns/1ns
module i2creg_top_checker (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Engine
  input  wire logic        addr_match,
  input  wire logic        engine_run,
  input  wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Offsets outside the decoded map
  logic hole;
  assign hole = (paddr > 8'h38 && paddr < 8'h48) || paddr > 8'h5C;

  //////////////////////////////////////////////////////////////////////////////
  // Access steps
  sequence s_acc;
    psel && penable && pready;
  endsequence
  sequence s_rd;
    s_acc ##0 !pwrite;
  endsequence
  sequence s_src_rd;
    s_rd ##0 paddr == 8'h28 ##0 $past(irq);
  endsequence

  property p_hole_err;
    s_acc ##0 hole |-> pslverr;
  endproperty
  a_hole_err: assert property (p_hole_err) else $error("unmapped access without error");
  property p_map_ok;
    s_acc ##0 !hole |-> !pslverr;
  endproperty
  a_map_ok: assert property (p_map_ok) else $error("mapped access flagged as error");
  property p_hole_zero;
    s_rd ##0 hole |-> prdata == 32'h0000_0000;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
  property p_own_address_field_rsv;
    s_rd ##0 paddr == 8'h00 |-> prdata[31:10] == 22'h0;
  endproperty
  a_own_address_field_rsv: assert property (p_own_address_field_rsv) else $error("own address upper bits set");
  property p_ien_rsv;
    s_rd ##0 paddr == 8'h04 |-> prdata[31:7] == 25'h0;
  endproperty
  a_ien_rsv: assert property (p_ien_rsv) else $error("enable upper bits set");
  property p_src_code;
    s_src_rd |-> prdata[31:3] == 29'h0 && prdata[2:0] != 3'h0;
  endproperty
  a_src_code: assert property (p_src_code) else $error("source code missing");
  property p_src_drop;
    s_src_rd |-> ##[1:2] !irq;
  endproperty
  a_src_drop: assert property (p_src_drop) else $error("request kept after source read");
  // Stopped engine never claims an address
  property p_off_nomatch;
    !engine_run [*2] |-> !addr_match;
  endproperty
  a_off_nomatch: assert property (p_off_nomatch) else $error("match while stopped");
endmodule // i2creg_top_checker

bind i2creg_top i2creg_top_checker u_i2creg_top_checker (
  .pclk       (pclk),
  .presetn    (presetn),
  .psel       (psel),
  .penable    (penable),
  .pwrite     (pwrite),
  .paddr      (paddr),
  .prdata     (prdata),
  .pready     (pready),
  .pslverr    (pslverr),
  .addr_match (addr_match),
  .engine_run (engine_run),
  .irq        (irq)
);

// file: testbench.sv
/*
  Self-checking bench for the register front end: reads queue their
  expectations, a monitor compares them as answers complete.
  Assumes the APB host model and the bound checker.
*/
`timescale 1ns/1ns
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [7:0]  rx_byte = 8'h00;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  evt_set = 7'h00;
  logic        rx_byte_valid = 1'b0;
  logic [9:0]  bus_addr = 10'h000;
  logic        scl_in = 1'b1;
  logic        sda_in = 1'b1;
  logic        addr_match, engine_run, irq, scl_oe, sda_oe, scl_out, sda_out;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  logic [7:0]  holes[4] = '{8'h3C, 8'h40, 8'h44, 8'h60};
  logic [31:0] modes[4] = '{32'h4020, 32'h4020, 32'h4120, 32'h4120};
  logic [9:0]  busa[4] = '{10'h025, 10'h1A5, 10'h1A5, 10'h3A5};
  logic        hits[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  int          errors = 0;
  int          cmp_count = 0;
  int          seed = 46300;
  int          s;

  // 20 MHz clock
  always #25 pclk = ~pclk;

  i2creg_top u_i2creg_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_set(evt_set),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .bus_addr(bus_addr),
    .addr_match(addr_match), .engine_run(engine_run), .irq(irq),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl_out(scl_out), .sda_out(sda_out)
  );
  i2creg_apb_host u_i2creg_apb_host (
    .pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_i2creg_apb_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    exp_q.push_back({e, d});
    u_i2creg_apb_host.xfer(1'b0, a, 32'h0);
  endtask
  // One-cycle engine pulse, then time for flag and request to settle
  task automatic pulse(input logic [6:0] ev, input logic rv);
    @(posedge pclk);
    evt_set       <= ev;
    rx_byte_valid <= rv;
    @(posedge pclk);
    evt_set       <= 7'h00;
    rx_byte_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Monitor: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      exp_v = exp_q.pop_front();
      chk({pslverr, prdata}, exp_v);
    end
  end

  // Watchdog, about thirty times the expected run
  initial begin
    #500000;
    errors++;
    end_sim;
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h10);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      wr(8'h00, r);
      rd(8'h00, r & 32'h3FF);
      wr(8'h04, ~r);
      rd(8'h04, ~r & 32'h7F);
    end
    // Reserved offsets are only ever read, never written
    foreach (holes[i]) rd(holes[i], 32'h0, 1'b1);
    // Free-run bit set throughout; it must change nothing
    wr(8'h00, 32'h3A5);
    for (int i = 0; i < 4; i++) begin
      wr(8'h24, modes[i]);
      bus_addr <= busa[i];
      repeat (3) @(posedge pclk);
      chk({31'h0, engine_run, addr_match}, {31'h0, 1'b1, hits[i]});
    end
    rd(8'h08, 32'h10);
    wr(8'h08, 32'h7F);
    rd(8'h08, 32'h0);
    wr(8'h04, 32'h0);
    pulse(7'h7F, 1'b0);
    chk({32'h0, irq}, 33'h0);
    rd(8'h08, 32'h7F);
    rd(8'h08, 32'h7F);
    wr(8'h08, 32'h7F);
    for (s = 0; s < 7; s++) begin
      wr(8'h04, 32'h1 << s);
      r = $random(seed);
      rx_byte <= r[7:0];
      pulse((s == 3) ? 7'h00 : (7'h01 << s), s == 3);
      chk({32'h0, irq}, 33'h1);
      if (s == 3)
        rd(8'h18, {24'h0, r[7:0]});
      else
        rd(8'h28, 32'(s + 1));
      repeat (3) @(posedge pclk);
      chk({32'h0, irq}, 33'h0);
      rd(8'h08, 32'h0);
    end
    wr(8'h04, 32'h7F);
    pulse(7'h22, 1'b0);
    rd(8'h08, 32'h22);
    rd(8'h28, 32'h2);
    repeat (4) @(posedge pclk);
    chk({32'h0, irq}, 33'h1);
    rd(8'h28, 32'h6);
    repeat (4) @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    pulse(7'h05, 1'b0);
    wr(8'h24, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, engine_run, addr_match}, 33'h0);
    rd(8'h08, 32'h10);
    // Pins pulled low when stopped only as the pin registers ask, released once running
    chk({29'h0, scl_oe, sda_oe, scl_out, sda_out}, 33'h0);
    wr(8'h48, 32'h1);
    wr(8'h4C, 32'h3);
    repeat (2) @(posedge pclk);
    chk({29'h0, scl_oe, sda_oe, scl_out, sda_out}, 33'hC);
    wr(8'h58, 32'h1);
    repeat (2) @(posedge pclk);
    chk({29'h0, scl_oe, sda_oe, scl_out, sda_out}, 33'h4);
    rd(8'h50, 32'h3);
    wr(8'h24, 32'h20);
    repeat (2) @(posedge pclk);
    chk({29'h0, scl_oe, sda_oe, scl_out, sda_out}, 33'h0);
    // Every queued read must have been answered
    chk(33'(exp_q.size()), 33'h0);
    @(posedge pclk);
    end_sim;
  end
endmodule // testbench
